// file: bench/d3cp_props.sv
`timescale 1ns/10ps
module d3cp_props import d3cp_pkg::*; #(
   parameter int RL = 5,
   parameter int WL = 5
) (
   input wire logic ck,
   input wire logic ck_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic dev_dq_oe,
   input wire logic dev_dqs_o,
   input wire logic dev_dqs_oe,
   input wire logic ctl_dq_oe,
   input wire logic ctl_dqs_o,
   input wire logic ctl_dqs_oe
);
   logic [3:0] cmd;
   logic cke_q;
   logic cke_r;
   logic rd_go;
   logic wr_go;
   logic cmd_go;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   // cke high at two rises, otherwise the edge is a power-down exit
   assign rd_go = (cmd == CMD_RD) && cke && cke_q;
   assign wr_go = (cmd == CMD_WR) && cke && cke_q;
   assign cmd_go = cke && (cmd inside {CMD_MRS, CMD_PRE, CMD_ACT, CMD_WR,
      CMD_RD});
   always_ff @(posedge ck or negedge reset_n) begin
      if (!reset_n) begin
         cke_r <= 1'b0;
      end else begin
         cke_r <= cke;
      end
   end
   // cke moves on the fall, so take it from the rise to avoid a race
   always_ff @(negedge ck or negedge reset_n) begin
      if (!reset_n) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= cke_r;
      end
   end
   // negedge sampling sees what the preceding rise captured
   // read strobe idles low and is high on the first beat
   sequence rd_beats;
      (dev_dq_oe && dev_dqs_o) ##1 (dev_dq_oe && !dev_dqs_o) ##1
      (dev_dq_oe && dev_dqs_o) ##1 (dev_dq_oe && !dev_dqs_o);
   endsequence
   sequence wr_beats;
      (ctl_dq_oe && ctl_dqs_oe) ##1 (ctl_dq_oe && ctl_dqs_oe);
   endsequence
   chk_ck_pair_rise: assert property (@(posedge ck)
      disable iff (!reset_n) ck_n) else $error("ck_n low at ck rise");
   chk_ck_pair_fall: assert property (@(negedge ck)
      disable iff (!reset_n) !ck_n) else $error("ck_n high at ck fall");
   chk_rd_latency: assert property (@(negedge ck)
      disable iff (!reset_n) rd_go |-> ##RL rd_beats)
      else $error("read burst late or strobe wrong");
   chk_rd_toggle: assert property (@(negedge ck)
      disable iff (!reset_n) dev_dqs_oe && $past(dev_dqs_oe) |->
      dev_dqs_o != $past(dev_dqs_o)) else $error("read strobe stuck");
   chk_oe_pair: assert property (@(negedge ck)
      disable iff (!reset_n) dev_dq_oe == dev_dqs_oe)
      else $error("data and strobe enables differ");
   chk_oe_cause: assert property (@(negedge ck)
      disable iff (!reset_n) $rose(dev_dq_oe) |-> $past(rd_go, RL))
      else $error("device drove bus without a read");
   chk_bus_free: assert property (@(negedge ck)
      disable iff (!reset_n) !(dev_dq_oe && ctl_dq_oe))
      else $error("both ends drive data");
   chk_wr_latency: assert property (@(negedge ck)
      disable iff (!reset_n) wr_go |-> ##WL wr_beats)
      else $error("write data late");
   chk_wr_strobe: assert property (@(negedge ck)
      disable iff (!reset_n) ctl_dqs_oe && $past(ctl_dqs_oe) |->
      ctl_dqs_o != $past(ctl_dqs_o)) else $error("write strobe stuck");
   chk_cmd_one_ck: assert property (@(negedge ck)
      disable iff (!reset_n) cmd_go |=> cs_n)
      else $error("command held past one clock");
endmodule

// file: bench/ddr3_control_pin_behaviour_tb.sv
`timescale 1ns/10ps
module ddr3_control_pin_behaviour_tb import d3cp_pkg::*; ;
   logic sys_clk;
   logic rst;
   logic dram_reset;
   logic req_valid;
   logic req_ready;
   d3cp_op_type req_op;
   logic [BA_W-1:0] req_ba;
   logic [ADDR_W-1:0] req_addr;
   logic req_odt;
   logic [63:0] wr_data;
   logic [7:0] wr_mask;
   logic rd_valid;
   logic [63:0] rd_data;
   logic [1:0] pwr_state;
   logic self_refresh;
   logic [7:0] term_dq;
   logic term_dqs;
   logic term_dm;
   logic [7:0] row_open;
   logic [63:0] mem [8];
   logic [63:0] exp_q [$];
   logic [63:0] care_q [$];
   logic [63:0] e;
   logic [63:0] c;
   logic tdqs_on;
   int seed = 32'h5bb2c048;
   int n_fail = 0;
   int compares = 0;
   d3cp_if #(.DQ_W(8)) lnk ();
   d3cp_ctl i_d3cp_ctl (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
      .dram_reset(dram_reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_ba(req_ba),
      .req_addr(req_addr), .req_odt(req_odt), .wr_data(wr_data),
      .wr_mask(wr_mask), .rd_valid(rd_valid), .rd_data(rd_data));
   d3cp_dram i_d3cp_dram (.lnk(lnk), .pwr_state(pwr_state),
      .self_refresh(self_refresh), .term_dq(term_dq), .term_dqs(term_dqs),
      .term_dm(term_dm), .row_open(row_open));
   d3cp_props #(.RL(5), .WL(5)) i_d3cp_props (.ck(lnk.ck), .ck_n(lnk.ck_n),
      .cke(lnk.cke), .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
      .we_n(lnk.we_n), .reset_n(lnk.reset_n), .dev_dq_oe(lnk.dev_dq_oe),
      .dev_dqs_o(lnk.dev_dqs_o), .dev_dqs_oe(lnk.dev_dqs_oe),
      .ctl_dq_oe(lnk.ctl_dq_oe), .ctl_dqs_o(lnk.ctl_dqs_o),
      .ctl_dqs_oe(lnk.ctl_dqs_oe));
   always #25 sys_clk = ~sys_clk;
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_rdy;
      int i;
      @(negedge sys_clk);
      for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
      chk(req_ready === 1'b1, "controller stuck busy");
   endtask
   // valid holds until the edge that takes it, then drops
   task automatic op(input d3cp_op_type o, input int b, input logic [15:0] ad,
      input logic od, input logic [63:0] wd, input logic [7:0] wm);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op <= o;
      req_ba <= 3'(b);
      req_addr <= ad;
      req_odt <= od;
      wr_data <= wd;
      wr_mask <= wm;
      wait_rdy();
      @(posedge sys_clk);
      req_valid <= 1'b0;
      wait_rdy();
   endtask
   task automatic go(input d3cp_op_type o, input int b, input logic [15:0] ad);
      op(o, b, ad, 1'b0, 64'h0, 8'h00);
   endtask
   task automatic wr(input int b, input logic [7:0] m);
      logic [63:0] d;
      d = {$random(seed), $random(seed)};
      for (int k = 0; k < 8; k++) begin
         if (!m[k] || tdqs_on) begin
            mem[b][k*8 +: 8] = d[k*8 +: 8];
         end
      end
      op(OP_WR, b, 16'h1000, 1'b0, d, m);
   endtask
   task automatic rd(input int b, input logic [15:0] ad, input logic [63:0] cm);
      exp_q.push_back(mem[b]);
      care_q.push_back(cm);
      go(OP_RD, b, ad);
   endtask
   // odt may take a few clocks to reach the pins, so poll a bounded while
   task automatic wait_term(input logic on);
      int i;
      for (i = 0; i < 200 && term_dq !== {8{on}}; i++) @(negedge sys_clk);
      chk(term_dq === {8{on}} && term_dqs === on && term_dm === on,
         "termination state");
   endtask
   always @(negedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "read data without request");
         end else begin
            e = exp_q.pop_front();
            c = care_q.pop_front();
            chk(((rd_data ^ e) & c) === 64'h0, "read data");
         end
      end
   end
   initial begin
      repeat (80000) @(posedge sys_clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      int i;
      sys_clk = 1'b0;
      rst = 1'b1;
      dram_reset = 1'b0;
      req_valid = 1'b0;
      req_op = OP_NOP;
      req_ba = '0;
      req_addr = '0;
      req_odt = 1'b0;
      wr_data = '0;
      wr_mask = '0;
      tdqs_on = 1'b0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      // cke leaves reset low, so the device starts powered down
      go(OP_PDX, 0, 16'h0000);
      chk(pwr_state === 2'h0 && lnk.cke === 1'b1, "cke raise");
      for (int b = 0; b < 8; b++) begin
         go(OP_ACT, b, 16'h0000);
         chk(row_open[b] === 1'b1, "row not open");
         wr(b, 8'h00);
         wr(b, 8'($random(seed)));
         rd(b, 16'h1000, '1);
      end
      go(OP_PDE, 0, 16'h0000);
      chk(pwr_state === 2'h2 && lnk.cke === 1'b0, "active pd");
      go(OP_PDX, 0, 16'h0000);
      chk(pwr_state === 2'h0 && row_open === 8'hff, "pd exit");
      go(OP_PRE, 0, 16'h0400);
      chk(row_open === 8'h00, "precharge all");
      go(OP_PDE, 0, 16'h0000);
      chk(pwr_state === 2'h1, "precharge pd");
      go(OP_PDX, 0, 16'h0000);
      chk(pwr_state === 2'h0 && lnk.cke === 1'b1, "pd exit");
      go(OP_SRE, 0, 16'h0000);
      chk(self_refresh === 1'b1, "self refresh entry");
      go(OP_SRX, 0, 16'h0000);
      chk(self_refresh === 1'b0, "self refresh exit");
      op(OP_NOP, 0, 16'h0000, 1'b1, 64'h0, 8'h00);
      wait_term(1'b0);
      go(OP_MRS, 1, 16'h0001 << RTT_B0);
      op(OP_NOP, 0, 16'h0000, 1'b1, 64'h0, 8'h00);
      wait_term(1'b1);
      op(OP_NOP, 0, 16'h0000, 1'b0, 64'h0, 8'h00);
      wait_term(1'b0);
      go(OP_MRS, 0, {14'h0, BL_OTF});
      go(OP_ACT, 3, 16'h0000);
      rd(3, 16'h0000, 64'h0000_0000_ffff_ffff);
      rd(3, 16'h1000, '1);
      go(OP_PRE, 0, 16'h0400);
      go(OP_MRS, 0, 16'h0000);
      go(OP_MRS, 1, (16'h0001 << TDQS_BIT) | (16'h0001 << RTT_B0));
      op(OP_NOP, 0, 16'h0000, 1'b1, 64'h0, 8'h00);
      chk(lnk.tdqs === 1'b1 && term_dm === 1'b0,
         "termination strobe");
      tdqs_on = 1'b1;
      go(OP_ACT, 3, 16'h0000);
      wr(3, 8'hff);
      rd(3, 16'h1000, '1);
      for (i = 0; i < 2000 && exp_q.size() != 0; i++) @(negedge sys_clk);
      chk(exp_q.size() == 0, "reads missing");
      @(posedge sys_clk);
      dram_reset <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(lnk.reset_n === 1'b0 && row_open === 8'h00 && lnk.tdqs === 1'b0
         && lnk.dev_dq_oe === 1'b0, "device reset");
      give_verdict();
   end
endmodule

// file: hw/d3cp_ctl.sv
`timescale 1ns/10ps
module d3cp_ctl import d3cp_pkg::*; #(
   parameter int DQ_W = 8,
   parameter int CK_HALF = 2,
   parameter int RL = 5,
   parameter int WL = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   d3cp_if.ctl lnk,
   input wire logic dram_reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire d3cp_op_type req_op,
   input wire logic [BA_W-1:0] req_ba,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic req_odt,
   input wire logic [BEATS8*DQ_W-1:0] wr_data,
   input wire logic [BEATS8-1:0] wr_mask,
   output logic rd_valid,
   output logic [BEATS8*DQ_W-1:0] rd_data
);
   initial begin
      if (CK_HALF < 2 || RL < 1 || WL < 1 || !(DQ_W == 4 || DQ_W == 8))
         $error("d3cp_ctl: unsupported parameters");
   end
   localparam int HW = $clog2(CK_HALF + 1);
   localparam int CW = 5;
   typedef enum {C_IDLE, C_CMD, C_RUN} d3cp_cst_type;
   d3cp_cst_type st, next_st;
   logic [HW-1:0] hc, next_hc;
   logic ck, next_ck, run, next_run;
   logic cke, next_cke, odt, next_odt, rstn, next_rstn;
   logic odt_req, next_odt_req;
   logic [3:0] cmd, next_cmd;
   logic [BA_W-1:0] ba, next_ba;
   logic [ADDR_W-1:0] a, next_a;
   logic [1:0] blm, next_blm;
   logic b8, next_b8;
   d3cp_op_type op, next_op;
   logic [BEATS8*DQ_W-1:0] wd, next_wd, rd, next_rd;
   logic [BEATS8-1:0] wm, next_wm;
   logic [CW-1:0] cnt, next_cnt, c1;
   logic [3:0] rc, next_rc;
   logic [DQ_W-1:0] dqo, next_dqo;
   logic dqoe, next_dqoe, dqso, next_dqso, dm, next_dm, rv, next_rv;
   logic [DQ_W-1:0] dq_s1, dq_s2;
   logic dqs_s1, dqs_s2, dqs_s3;
   logic tick, rise_t, fall_t;
   logic [3:0] beats;
   logic [2:0] k;

   assign tick = hc == HW'(CK_HALF - 1);
   assign rise_t = tick & ~ck & run;
   // while the clock is parked, pseudo falls still pace the pins
   assign fall_t = tick & (ck | ~run);
   assign beats = b8 ? 4'(BEATS8) : 4'(BEATS4);
   assign c1 = cnt + 1'b1;
   assign k = 3'(c1 - CW'(WL));
   assign req_ready = st == C_IDLE;

   always_comb begin
      next_st = st;
      next_hc = tick ? '0 : hc + 1'b1;
      next_ck = tick ? (~ck & run) : ck;
      next_run = run;
      next_cke = cke;
      next_odt = odt;
      next_odt_req = odt_req;
      next_rstn = ~dram_reset;
      next_cmd = cmd;
      next_ba = ba;
      next_a = a;
      next_blm = blm;
      next_b8 = b8;
      next_op = op;
      next_wd = wd;
      next_wm = wm;
      next_rd = rd;
      next_cnt = cnt;
      next_rc = rc;
      next_dqo = dqo;
      next_dqoe = dqoe;
      next_dqso = dqso;
      next_dm = dm;
      next_rv = 1'b0;
      case (st)
         C_IDLE: begin
            if (req_valid) begin
               next_op = req_op;
               next_ba = req_ba;
               next_a = req_addr;
               next_odt_req = req_odt;
               next_wd = wr_data;
               next_wm = wr_mask;
               next_st = C_CMD;
            end
         end
         C_CMD: begin
            if (fall_t) begin
               next_cnt = '0;
               next_rc = '0;
               next_st = C_RUN;
               next_cmd = CMD_NOP;
               // odt moves on a fall, never on the sampling rise
               next_odt = odt_req;
               case (op)
                  OP_MRS: next_cmd = CMD_MRS;
                  OP_ACT: next_cmd = CMD_ACT;
                  OP_PRE: next_cmd = CMD_PRE;
                  OP_REF: next_cmd = CMD_REF;
                  OP_RD: next_cmd = CMD_RD;
                  OP_WR: next_cmd = CMD_WR;
                  OP_PDE: next_cke = 1'b0;
                  OP_PDX: next_cke = 1'b1;
                  OP_SRE: begin
                     next_cmd = CMD_REF;
                     next_cke = 1'b0;
                  end
                  OP_SRX: begin
                     // cke rises with the clock parked (RULE3)
                     next_cke = 1'b1;
                     next_run = 1'b1;
                  end
                  default: next_cmd = CMD_NOP;
               endcase
               if (op == OP_MRS && ba == 3'h0)
                  next_blm = a[BL_LSB+1:BL_LSB];
               // (RULE19)
               next_b8 = (blm == BL_OTF) ? a[BC_BIT] : (blm != BL_BC4);
            end
         end
         C_RUN: begin
            if (rise_t && dqoe)
               next_dqso = ~dqso; // (RULE14)
            if (op == OP_RD && dqs_s2 != dqs_s3) begin
               next_rd[rc[2:0]*DQ_W +: DQ_W] = dq_s2;
               next_rc = rc + 1'b1;
            end
            if (fall_t) begin
               next_cnt = c1;
               next_cmd = CMD_DES;
               if (op == OP_SRE)
                  next_run = 1'b0;
               if (op == OP_WR && c1 >= CW'(WL) && c1 < CW'(WL) + 5'(beats))
               begin
                  next_dqoe = 1'b1;
                  next_dqo = wd[k*DQ_W +: DQ_W];
                  next_dm = wm[k]; // (RULE8)
               end else begin
                  next_dqoe = 1'b0;
                  next_dm = 1'b0;
                  next_dqso = 1'b0;
               end
               if (op != OP_RD && op != OP_WR)
                  next_st = C_IDLE;
               if (op == OP_WR && c1 == CW'(WL) + 5'(beats))
                  next_st = C_IDLE;
            end
            if (op == OP_RD && rc == beats) begin
               next_rv = 1'b1;
               next_st = C_IDLE;
            end
         end
         default: next_st = C_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      dq_s1 <= lnk.dq;
      dq_s2 <= dq_s1;
      dqs_s1 <= lnk.dqs;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
      wd <= next_wd;
      wm <= next_wm;
      rd <= next_rd;
      dqo <= next_dqo;
      ba <= next_ba;
      a <= next_a;
      op <= next_op;
      odt_req <= next_odt_req;
      if (rst) begin
         st <= C_IDLE;
         hc <= '0;
         ck <= 1'b0;
         run <= 1'b1;
         cke <= 1'b0;
         odt <= 1'b0;
         rstn <= 1'b0;
         cmd <= CMD_DES;
         blm <= BL_FIX8;
         b8 <= 1'b1;
         cnt <= '0;
         rc <= '0;
         dqoe <= 1'b0;
         dqso <= 1'b0;
         dm <= 1'b0;
         rv <= 1'b0;
      end else begin
         st <= next_st;
         hc <= next_hc;
         ck <= next_ck;
         run <= next_run;
         cke <= next_cke;
         odt <= next_odt;
         rstn <= next_rstn;
         cmd <= next_cmd;
         blm <= next_blm;
         b8 <= next_b8;
         cnt <= next_cnt;
         rc <= next_rc;
         dqoe <= next_dqoe;
         dqso <= next_dqso;
         dm <= next_dm;
         rv <= next_rv;
      end
   end

   assign lnk.ck = ck;
   assign lnk.ck_n = ~ck;
   assign lnk.cke = cke;
   assign {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} = cmd; // (RULE7)
   assign lnk.odt = odt;
   assign lnk.reset_n = rstn;
   assign lnk.ba = ba;
   assign lnk.a = a;
   assign lnk.dm = dm;
   assign lnk.ctl_dq_o = dqo;
   assign lnk.ctl_dq_oe = dqoe;
   assign lnk.ctl_dqs_o = dqso;
   assign lnk.ctl_dqs_oe = dqoe;
   assign rd_valid = rv;
   assign rd_data = rd;
endmodule

// file: hw/d3cp_dram.sv
`timescale 1ns/10ps
// How it works
// (RULE1) registered cke gates all internal activity
// (RULE2) cke low: precharge, self refresh or active pd
// (RULE3) cke sync except async self refresh exit
// (RULE4) power-down keeps only clock, cke, reset, odt
// (RULE5) self refresh keeps only cke and reset
// (RULE6) commands decoded only with chip select low
// (RULE7) command code includes chip select
// (RULE8) masked write beats are not stored
// (RULE9) odt registered high turns termination on
// (RULE10) termination on data, strobe and mask only
// (RULE11) mode register can disable odt entirely
// (RULE12) reset low acts asynchronously both ways
// (RULE13) read strobe edges aligned with data
// (RULE14) write strobe centred in each data beat
// (RULE15) x8 termination strobe disables the mask
// (RULE16) x8 adds upper data and termination strobe
// (RULE17) all pins sampled on rising clock crossing
// (RULE18) bank bits pick bank or mode register
// (RULE19) a12 picks eight or four beat burst
// (RULE20) data and strobe idle unless reading
module d3cp_dram import d3cp_pkg::*; #(
   parameter int DQ_W = 8,
   parameter int RL = 5,
   parameter int WL = 5,
   parameter int COL_W = 3
) (
   d3cp_if.dev lnk,
   output logic [1:0] pwr_state,
   output logic self_refresh,
   output logic [DQ_W-1:0] term_dq,
   output logic term_dqs,
   output logic term_dm,
   output logic [NUM_BANK-1:0] row_open
);
   initial begin
      if (!(DQ_W == 4 || DQ_W == 8) || RL < 1 || WL < 1 || COL_W < 1)
         $error("d3cp_dram: unsupported parameters");
   end
   localparam bit X8 = DQ_W == 8; // (RULE16)
   localparam int MAX_L = RL > WL ? RL : WL;
   localparam int CNT_W = $clog2(MAX_L + BEATS8 + 1);
   localparam int MEM_AW = BA_W + COL_W + 3;
   localparam logic [CNT_W-1:0] RL_C = CNT_W'(RL);
   localparam logic [CNT_W-1:0] WL_C = CNT_W'(WL);
   typedef enum logic [1:0] {PWR_ON, PWR_PD_PRE, PWR_PD_ACT} d3cp_pwr_type;

   d3cp_pwr_type pwr, next_pwr;
   logic sr, next_sr;
   logic [ADDR_W-1:0] mr [NUM_MR];
   logic [ADDR_W-1:0] next_mr [NUM_MR];
   logic [NUM_BANK-1:0] opn, next_opn;
   logic odt_q, next_odt_q;
   logic [CNT_W-1:0] rd_cnt, next_rd_cnt, wr_cnt, next_wr_cnt;
   logic rd_b8, next_rd_b8, wr_b8, next_wr_b8;
   logic [MEM_AW-4:0] rd_adr, next_rd_adr, wr_adr, next_wr_adr;
   logic [DQ_W-1:0] dq_o, next_dq_o;
   logic dq_oe, next_dq_oe, dqs_o, next_dqs_o;
   logic [DQ_W-1:0] mem [2**MEM_AW];
   logic mem_we;
   logic [MEM_AW-1:0] mem_wa;
   logic [2:0] rbeat, wbeat;
   logic [3:0] cmd;
   logic awake, dec, bl8, rtt_on, tdqs_en, term_on, mask_on;
   logic [CNT_W-1:0] rlen, wlen;

   assign cmd = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n}; // (RULE7)
   assign awake = pwr == PWR_ON && !sr;
   // (RULE6)
   assign dec = awake && lnk.cke && !lnk.cs_n; // (RULE1)
   // (RULE19)
   assign bl8 = (mr[0][BL_LSB+1:BL_LSB] == BL_OTF) ? lnk.a[BC_BIT] :
                (mr[0][BL_LSB+1:BL_LSB] != BL_BC4);
   // (RULE11)
   assign rtt_on = mr[1][RTT_B0] | mr[1][RTT_B1] | mr[1][RTT_B2];
   assign tdqs_en = X8 && mr[1][TDQS_BIT];
   assign rlen = rd_b8 ? CNT_W'(BEATS8) : CNT_W'(BEATS4);
   assign wlen = wr_b8 ? CNT_W'(BEATS8) : CNT_W'(BEATS4);
   assign rbeat = 3'(rd_cnt - RL_C);
   assign wbeat = 3'(wr_cnt - WL_C);
   // (RULE15)
   assign mask_on = tdqs_en ? 1'b0 : lnk.dm;

   always_comb begin
      next_pwr = pwr;
      next_sr = sr;
      next_mr = mr;
      next_opn = opn;
      next_rd_cnt = rd_cnt;
      next_wr_cnt = wr_cnt;
      next_rd_b8 = rd_b8;
      next_wr_b8 = wr_b8;
      next_rd_adr = rd_adr;
      next_wr_adr = wr_adr;
      next_dq_o = dq_o;
      next_dq_oe = 1'b0;
      next_dqs_o = 1'b0;
      // odt buffer stays live in power-down too, off only in self refresh (RULE4)
      next_odt_q = sr ? 1'b0 : lnk.odt; // (RULE5)
      mem_we = 1'b0;
      mem_wa = {wr_adr, wbeat};
      case (pwr)
         PWR_ON: begin
            if (!sr && !lnk.cke) begin
               // (RULE2)
               if (!lnk.cs_n && cmd == CMD_REF && opn == '0)
                  next_sr = 1'b1;
               else if (opn == '0)
                  next_pwr = PWR_PD_PRE;
               else
                  next_pwr = PWR_PD_ACT;
            end
         end
         PWR_PD_PRE, PWR_PD_ACT: begin
            if (lnk.cke)
               next_pwr = PWR_ON; // (RULE3)
         end
         default: next_pwr = PWR_ON;
      endcase
      if (dec) begin
         case (cmd)
            CMD_MRS: begin
               if (!lnk.ba[2])
                  next_mr[lnk.ba[1:0]] = lnk.a; // (RULE18)
            end
            CMD_ACT: next_opn[lnk.ba] = 1'b1;
            CMD_PRE: begin
               if (lnk.a[AP_BIT])
                  next_opn = '0;
               else
                  next_opn[lnk.ba] = 1'b0;
            end
            CMD_RD: begin
               next_rd_cnt = CNT_W'(1);
               next_rd_b8 = bl8;
               next_rd_adr = {lnk.ba, lnk.a[COL_W+2:3]};
            end
            CMD_WR: begin
               next_wr_cnt = CNT_W'(1);
               next_wr_b8 = bl8;
               next_wr_adr = {lnk.ba, lnk.a[COL_W+2:3]};
            end
            default: next_pwr = pwr;
         endcase
      end
      if (rd_cnt != '0 && !(dec && cmd == CMD_RD)) begin
         next_rd_cnt = (rd_cnt == RL_C + rlen) ? '0 : rd_cnt + 1'b1;
         if (rd_cnt >= RL_C && rd_cnt < RL_C + rlen) begin
            // strobe toggles on the same edge as the data (RULE13)
            next_dq_o = mem[{rd_adr, rbeat}];
            next_dq_oe = 1'b1; // (RULE20)
            next_dqs_o = ~dqs_o;
         end
      end
      if (wr_cnt != '0 && !(dec && cmd == CMD_WR)) begin
         next_wr_cnt = (wr_cnt == WL_C + wlen - 1'b1) ? '0 : wr_cnt + 1'b1;
         // data lands at edges wl .. wl+len-1 after the command (RULE17)
         if (wr_cnt >= WL_C && awake)
            mem_we = ~mask_on; // (RULE8)
      end
   end

   // memory is not reset; contents are unknown until written
   always_ff @(posedge lnk.ck) begin
      if (mem_we)
         mem[mem_wa] <= lnk.dq;
   end

   // (RULE12)
   always_ff @(posedge lnk.ck or negedge lnk.reset_n) begin
      if (!lnk.reset_n) begin
         pwr <= PWR_ON;
         for (int i = 0; i < NUM_MR; i++)
            mr[i] <= MR_RST;
         opn <= '0;
         odt_q <= 1'b0;
         rd_cnt <= '0;
         wr_cnt <= '0;
         rd_b8 <= 1'b1;
         wr_b8 <= 1'b1;
         rd_adr <= '0;
         wr_adr <= '0;
         dq_o <= '0;
         dq_oe <= 1'b0;
         dqs_o <= 1'b0;
      end else begin
         pwr <= next_pwr;
         mr <= next_mr;
         opn <= next_opn;
         odt_q <= next_odt_q; // (RULE9)
         rd_cnt <= next_rd_cnt;
         wr_cnt <= next_wr_cnt;
         rd_b8 <= next_rd_b8;
         wr_b8 <= next_wr_b8;
         rd_adr <= next_rd_adr;
         wr_adr <= next_wr_adr;
         dq_o <= next_dq_o;
         dq_oe <= next_dq_oe;
         dqs_o <= next_dqs_o;
      end
   end

   // self refresh exit needs no clock edge: cke rising clears it (RULE3)
   always_ff @(posedge lnk.ck or negedge lnk.reset_n or posedge lnk.cke)
   begin
      if (!lnk.reset_n)
         sr <= 1'b0;
      else if (lnk.cke)
         sr <= 1'b0;
      else
         sr <= next_sr;
   end

   assign term_on = odt_q && rtt_on && !sr; // (RULE11)
   assign term_dq = {DQ_W{term_on}}; // (RULE10)
   assign term_dqs = term_on;
   assign term_dm = term_on && !tdqs_en; // (RULE15)
   assign lnk.tdqs = term_on && tdqs_en; // (RULE16)
   assign lnk.tdqs_n = term_on && tdqs_en;
   assign lnk.dev_dq_o = dq_o;
   assign lnk.dev_dq_oe = dq_oe; // (RULE20)
   assign lnk.dev_dqs_o = dqs_o;
   assign lnk.dev_dqs_oe = dq_oe;
   assign pwr_state = pwr;
   assign self_refresh = sr;
   assign row_open = opn;
endmodule

// file: pkg/d3cp_if.sv
`timescale 1ns/10ps
interface d3cp_if #(parameter int DQ_W = 8);
   logic ck;
   logic ck_n;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic reset_n;
   logic [2:0] ba;
   logic [15:0] a;
   logic dm;
   logic tdqs;
   logic tdqs_n;
   logic [DQ_W-1:0] dev_dq_o;
   logic dev_dq_oe;
   logic dev_dqs_o;
   logic dev_dqs_oe;
   logic [DQ_W-1:0] ctl_dq_o;
   logic ctl_dq_oe;
   logic ctl_dqs_o;
   logic ctl_dqs_oe;
   logic [DQ_W-1:0] dq;
   logic dqs;
   logic dqs_n;
   // undriven bus reads low
   assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
   assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe & ctl_dqs_o);
   assign dqs_n = ~dqs;
   modport dev (
      input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n,
      input ba, a, dm, dq, dqs, dqs_n,
      output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe, tdqs, tdqs_n
   );
   modport ctl (
      output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n,
      output ba, a, dm, ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
      input dq, dqs, dqs_n, tdqs, tdqs_n
   );
endinterface

// file: pkg/d3cp_pkg.sv
package d3cp_pkg;
   localparam int BA_W = 3;
   localparam int ADDR_W = 16;
   localparam int NUM_BANK = 8;
   localparam int NUM_MR = 4;
   localparam int BEATS8 = 8;
   localparam int BEATS4 = 4;
   // command code is {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam int BL_LSB = 0;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_BC4 = 2'h2;
   localparam int RTT_B0 = 2;
   localparam int RTT_B1 = 6;
   localparam int RTT_B2 = 9;
   localparam int TDQS_BIT = 11;
   localparam logic [ADDR_W-1:0] MR_RST = 16'h0000;
   typedef enum logic [3:0] {
      OP_NOP, OP_MRS, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF,
      OP_PDE, OP_PDX, OP_SRE, OP_SRX
   } d3cp_op_type;
endpackage
